/* hw/gsc_sc_channel.sv */
// Function
// - register address is the full 8-bit byte, decoded unchanged
// - sc byte carries six command/indicate bits then mr and mx
// - one sc byte per 4-byte subframe, exchanged every frame
// - rx bits: 7,6 reserved, 5 on-hook monitor, 4 gnd enable, 3 ring-gnd, 2 off-hook
// - host holds new commands two frames; device accepts only two matching frames
// - accepted commands held in primary; equal value causes no action
// - value differing from primary is latched into secondary same frame
// - next frame equal to secondary copies it to primary and acts
// - next value differing from both overwrites secondary, every frame
// - next value equal to primary discards secondary, primary unchanged
// - upstream bits driven on upstream pin, downstream read from downstream pin
// - upstream byte msb first: 7 reserved, 6 threshold, 5 drop-out, 2 tip-ground
// - upstream bit 4 mirrors interrupt pin level every frame
// - upstream bit 3 copies bit 7 of line voltage status
// - handshake idle is mr and mx high for two or more frames
module gsc_sc_channel #(
   parameter int SUBFRAME = 0
) (
   input  wire logic            refClk,
   input  wire logic            sysRst,
   input  wire logic            linkClk,
   input  wire logic            frameSync,
   input  wire logic            downstreamDataPin,
   output logic                 upstreamDataPin,
   output logic                 upstreamDataOe,
   input  gsc_pkg::gsc_status_s lineStatus,
   input  gsc_pkg::gsc_reg_req_s regReq,
   output logic [7:0]           regRdData,
   output logic [7:0]           hookControl,
   output gsc_pkg::gsc_cmd_s    cmdActive,
   output logic                 cmdAccepted,
   output logic                 cmdPending,
   output logic                 rxMr,
   output logic                 rxMx,
   output logic                 handshakeIdle
);
   localparam int FRAME_BITS = gsc_pkg::SUBFRAMES_PER_FRAME * gsc_pkg::BYTES_PER_SUBFRAME
                               * gsc_pkg::BITS_PER_BYTE;
   localparam int FRAME_EDGES = FRAME_BITS * gsc_pkg::CLKS_PER_BIT;
   localparam int EDGE_W = $clog2(FRAME_EDGES);
   localparam int BIT_W = $clog2(FRAME_BITS);
   localparam int SC_START = (SUBFRAME * gsc_pkg::BYTES_PER_SUBFRAME
                              + gsc_pkg::SC_BYTE_IN_SUBFRAME) * gsc_pkg::BITS_PER_BYTE;
   localparam logic [EDGE_W-1:0] EDGE_LAST = EDGE_W'(FRAME_EDGES - 1);
   localparam logic [BIT_W-1:0] SLOT_FIRST = BIT_W'(SC_START);
   localparam logic [BIT_W-1:0] SLOT_LAST = BIT_W'(SC_START + gsc_pkg::BITS_PER_BYTE - 1);

   // link pins cross into refClk domain
   logic [2:0]          pinStable;
   logic                linkClkS;
   logic                frameSyncS;
   logic                downDataS;

   gsc_pin_sync #(
      .WIDTH (3)
   ) u_pin_sync (
      .refClk    (refClk),
      .sysRst    (sysRst),
      .pinIn     ({linkClk, frameSync, downstreamDataPin}),
      .pinStable (pinStable)
   );

   assign linkClkS   = pinStable[2];
   assign frameSyncS = pinStable[1];
   assign downDataS  = pinStable[0];

   // link clock edge and frame position
   logic                linkClkPrev_q;
   logic                syncAtEdge_q;
   logic [EDGE_W-1:0]   edgeCnt_q;
   logic [EDGE_W-1:0]   edgeNext;
   logic                frameRun_q;
   wire                 linkRise   = linkClkS & ~linkClkPrev_q;
   wire                 frameStart = linkRise & frameSyncS & ~syncAtEdge_q;

   assign edgeNext = frameStart ? '0 :
                     (edgeCnt_q == EDGE_LAST) ? edgeCnt_q : edgeCnt_q + EDGE_W'(1);

   wire [BIT_W-1:0]     bitNext   = edgeNext[EDGE_W-1:1];
   wire                 bitSecond = edgeNext[0];
   wire [2:0]           bitInByte = bitNext[2:0];
   wire                 inSlot    = frameRun_q | frameStart ?
                                    (bitNext >= SLOT_FIRST) && (bitNext <= SLOT_LAST) : 1'b0;
   wire                 slotActive = linkRise & inSlot;
   wire                 txEdge    = slotActive & ~bitSecond;
   wire                 rxEdge    = slotActive & bitSecond;
   wire                 rxLastBit = rxEdge & (bitNext == SLOT_LAST);

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) begin
         linkClkPrev_q <= 1'b0;
         syncAtEdge_q  <= 1'b0;
         edgeCnt_q     <= EDGE_LAST;
         frameRun_q    <= 1'b0;
      end else begin
         linkClkPrev_q <= linkClkS;
         if (linkRise) begin
            syncAtEdge_q <= frameSyncS;
            edgeCnt_q    <= edgeNext;
         end
         if (frameStart) begin
            frameRun_q <= 1'b1;
         end
      end
   end

   // downstream sc byte, msb first
   logic [7:0]          rxShift_q;
   logic [7:0]          rxShift_d;
   logic                rxStb_q;
   logic [7:0]          rxByte_q;

   assign rxShift_d = {rxShift_q[6:0], downDataS};

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) begin
         rxShift_q <= '0;
         rxByte_q  <= '1;
         rxStb_q   <= 1'b0;
      end else begin
         rxStb_q <= rxLastBit;
         if (rxEdge) begin
            rxShift_q <= rxShift_d;
         end
         if (rxLastBit) begin
            rxByte_q <= rxShift_d;
         end
      end
   end

   // command field and handshake bits
   gsc_pkg::gsc_cmd_s   rxCmd;
   wire                 rxByteMr = rxByte_q[gsc_pkg::SC_MR_BIT];
   wire                 rxByteMx = rxByte_q[gsc_pkg::SC_MX_BIT];

   assign rxCmd = rxByte_q[gsc_pkg::SC_CMD_MSB:gsc_pkg::SC_CMD_LSB];

   gsc_ci_validator u_ci_validator (
      .refClk      (refClk),
      .sysRst      (sysRst),
      .rxStb       (rxStb_q),
      .rxCmd       (rxCmd),
      .cmdPrimary  (cmdActive),
      .cmdAccepted (cmdAccepted),
      .cmdPending  (cmdPending)
   );

   // handshake idle tracking
   logic                rxMr_q;
   logic                rxMx_q;
   logic [1:0]          idleFrames_q;
   logic [1:0]          idleFrames_d;
   logic                hsIdle_q;
   wire                 bothInactive = (rxByteMr == gsc_pkg::HS_INACTIVE)
                                       & (rxByteMx == gsc_pkg::HS_INACTIVE);

   assign idleFrames_d = !bothInactive ? 2'h0 :
                         (idleFrames_q == gsc_pkg::HS_IDLE_FRAMES) ? idleFrames_q :
                         idleFrames_q + 2'h1;

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) begin
         rxMr_q       <= gsc_pkg::HS_INACTIVE;
         rxMx_q       <= gsc_pkg::HS_INACTIVE;
         idleFrames_q <= '0;
         hsIdle_q     <= 1'b0;
      end else if (rxStb_q) begin
         rxMr_q       <= rxByteMr;
         rxMx_q       <= rxByteMx;
         idleFrames_q <= idleFrames_d;
         hsIdle_q     <= (idleFrames_d == gsc_pkg::HS_IDLE_FRAMES);
      end
   end

   assign rxMr          = rxMr_q;
   assign rxMx          = rxMx_q;
   assign handshakeIdle = hsIdle_q;

   // upstream sc byte, captured once per frame
   logic [7:0]          txByte_q;
   logic [7:0]          txByte_d;
   logic                txData_q;
   logic                txOe_q;

   always_comb begin
      txByte_d = '0;
      txByte_d[gsc_pkg::TX_RESERVED_BIT]   = gsc_pkg::TX_RESERVED_LEVEL;
      txByte_d[gsc_pkg::TX_THRESHOLD_BIT]  = lineStatus.thresholdCrossIndication;
      txByte_d[gsc_pkg::TX_DROP_OUT_BIT]   = lineStatus.dropOutDetect;
      txByte_d[gsc_pkg::TX_INT_PIN_BIT]    = lineStatus.intPinLevel;
      txByte_d[gsc_pkg::TX_POLARITY_BIT]   =
         lineStatus.lineVoltageStatus[gsc_pkg::LVS_POLARITY_BIT];
      txByte_d[gsc_pkg::TX_TIP_GROUND_BIT] = lineStatus.tipGroundDetect;
      txByte_d[gsc_pkg::SC_MR_BIT]         = gsc_pkg::HS_INACTIVE;
      txByte_d[gsc_pkg::SC_MX_BIT]         = gsc_pkg::HS_INACTIVE;
   end

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) begin
         txByte_q <= '1;
         txData_q <= 1'b1;
         txOe_q   <= 1'b0;
      end else begin
         if (frameStart) begin
            txByte_q <= txByte_d;
         end
         if (txEdge) begin
            // frame start edge loads the byte too, so use the fresh copy
            txData_q <= frameStart ? txByte_d[3'h7 - bitInByte]
                                   : txByte_q[3'h7 - bitInByte];
            txOe_q   <= 1'b1;
         end else if (linkRise & ~inSlot) begin
            txData_q <= 1'b1;
            txOe_q   <= 1'b0;
         end
      end
   end

   assign upstreamDataPin = txData_q;
   assign upstreamDataOe  = txOe_q;

   // register access, full address decode
   logic [7:0]          hookCtl_q;
   logic [7:0]          hookCtl_d;
   logic [7:0]          rdData_q;
   wire                 selHook  = (regReq.addr == gsc_pkg::REG_LINE_HOOK_CONTROL);
   wire                 selFault = (regReq.addr == gsc_pkg::REG_LINE_FAULT_STATUS);
   wire                 hookWr   = regReq.wrEn & selHook;
   wire [7:0]           faultRd  = 8'(lineStatus.dropOutDetect) << gsc_pkg::FAULT_DROP_OUT_BIT;
   wire [7:0]           rdMux    = selHook  ? hookCtl_q :
                                   selFault ? faultRd : gsc_pkg::READ_UNMAPPED;

   always_comb begin
      hookCtl_d = hookWr ? regReq.wrData : hookCtl_q;
      // a validated command change wins over a same-cycle write
      if (cmdAccepted) begin
         hookCtl_d[gsc_pkg::HOOK_ON_HOOK_MON_BIT] = cmdActive.onHookMonitor;
         hookCtl_d[gsc_pkg::HOOK_OFF_HOOK_BIT]    = cmdActive.offHookRequest;
      end
   end

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) begin
         hookCtl_q <= gsc_pkg::HOOK_CONTROL_RESET;
         rdData_q  <= '0;
      end else begin
         hookCtl_q <= hookCtl_d;
         if (regReq.rdEn) begin
            rdData_q <= rdMux;
         end
      end
   end

   assign regRdData   = rdData_q;
   assign hookControl = hookCtl_q;
endmodule // gsc_sc_channel

/* inc/gsc_pkg.sv */
package gsc_pkg;

   // register map, full 8-bit addresses
   localparam logic [7:0] REG_LINE_HOOK_CONTROL = 8'h05;
   localparam logic [7:0] REG_LINE_FAULT_STATUS = 8'h13;
   localparam logic [7:0] HOOK_CONTROL_RESET    = 8'h00;
   localparam logic [7:0] READ_UNMAPPED         = 8'h00;
   localparam int         HOOK_ON_HOOK_MON_BIT  = 3;
   localparam int         HOOK_OFF_HOOK_BIT     = 0;
   localparam int         FAULT_DROP_OUT_BIT    = 1;
   localparam int         LVS_POLARITY_BIT      = 7;

   // sc byte layout
   localparam int         SC_CMD_MSB            = 7;
   localparam int         SC_CMD_LSB            = 2;
   localparam int         SC_MR_BIT             = 1;
   localparam int         SC_MX_BIT             = 0;
   localparam int         TX_RESERVED_BIT       = 7;
   localparam int         TX_THRESHOLD_BIT      = 6;
   localparam int         TX_DROP_OUT_BIT       = 5;
   localparam int         TX_INT_PIN_BIT        = 4;
   localparam int         TX_POLARITY_BIT       = 3;
   localparam int         TX_TIP_GROUND_BIT     = 2;
   localparam logic       TX_RESERVED_LEVEL     = 1'b1;
   localparam logic       HS_INACTIVE           = 1'b1;
   localparam logic [1:0] HS_IDLE_FRAMES        = 2'h2;
   localparam logic [5:0] CMD_RESET             = 6'h00;

   // highway framing
   localparam int         BYTES_PER_SUBFRAME    = 4;
   localparam int         SC_BYTE_IN_SUBFRAME   = 3;
   localparam int         BITS_PER_BYTE         = 8;
   localparam int         CLKS_PER_BIT          = 2;
   localparam int         SUBFRAMES_PER_FRAME   = 8;
   localparam int         SYNC_STAGES           = 3;

   typedef struct packed {
      logic rxCmdBit6;
      logic rxCmdBit5;
      logic onHookMonitor;
      logic groundDetectEnable;
      logic ringGroundControl;
      logic offHookRequest;
   } gsc_cmd_s;

   typedef struct packed {
      logic       thresholdCrossIndication;
      logic       dropOutDetect;
      logic       intPinLevel;
      logic       tipGroundDetect;
      logic [7:0] lineVoltageStatus;
   } gsc_status_s;

   typedef struct packed {
      logic       wrEn;
      logic       rdEn;
      logic [7:0] addr;
      logic [7:0] wrData;
   } gsc_reg_req_s;

endpackage

/* hw/gsc_pin_sync.sv */
module gsc_pin_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             refClk,
   input  wire logic             sysRst,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinStable
);
   logic [WIDTH-1:0] stage1_q;
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] stable_q;
   logic [WIDTH-1:0] stable_d;

   // a change counts once stages two and three agree
   assign stable_d  = (stage2_q & stage3_q) | (stable_q & (stage2_q ^ stage3_q));
   assign pinStable = stable_q;

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) begin
         stage1_q <= '0;
         stage2_q <= '0;
         stage3_q <= '0;
         stable_q <= '0;
      end else begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         stable_q <= stable_d;
      end
   end
endmodule // gsc_pin_sync

/* hw/gsc_ci_validator.sv */
module gsc_ci_validator (
   input  wire logic          refClk,
   input  wire logic          sysRst,
   input  wire logic          rxStb,
   input  gsc_pkg::gsc_cmd_s  rxCmd,
   output gsc_pkg::gsc_cmd_s  cmdPrimary,
   output logic               cmdAccepted,
   output logic               cmdPending
);
   gsc_pkg::gsc_cmd_s primary_q;
   gsc_pkg::gsc_cmd_s primary_d;
   gsc_pkg::gsc_cmd_s second_q;
   gsc_pkg::gsc_cmd_s second_d;
   logic              pending_q;
   logic              pending_d;
   logic              accepted_q;
   logic              accepted_d;
   wire               matchPrimary = (rxCmd == primary_q);
   wire               matchSecond  = (rxCmd == second_q);
   wire               confirm      = rxStb & pending_q & ~matchPrimary & matchSecond;
   wire               latchNew     = rxStb & ~matchPrimary & ~confirm;

   assign primary_d   = confirm ? second_q : primary_q;
   assign second_d    = latchNew ? rxCmd : second_q;
   // equal to primary: no action, any pending value is dropped
   assign pending_d   = rxStb ? latchNew : pending_q;
   assign accepted_d  = confirm;
   assign cmdPrimary  = primary_q;
   assign cmdAccepted = accepted_q;
   assign cmdPending  = pending_q;

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) begin
         primary_q  <= gsc_pkg::CMD_RESET;
         second_q   <= gsc_pkg::CMD_RESET;
         pending_q  <= 1'b0;
         accepted_q <= 1'b0;
      end else begin
         primary_q  <= primary_d;
         second_q   <= second_d;
         pending_q  <= pending_d;
         accepted_q <= accepted_d;
      end
   end
endmodule // gsc_ci_validator

/* tb/gsc_sc_channel_asserts.sv */
module gsc_sc_channel_asserts (
   input wire logic              refClk,
   input wire logic              sysRst,
   input wire logic              upstreamDataPin,
   input wire logic              upstreamDataOe,
   input wire logic [7:0]        hookControl,
   input wire gsc_pkg::gsc_cmd_s cmdActive,
   input wire logic              cmdAccepted,
   input wire logic              cmdPending,
   input wire logic              rxMr,
   input wire logic              rxMx,
   input wire logic              handshakeIdle
);
   // cycles the upstream enable has stood high
   logic [8:0] oeCnt_q;

   always_ff @(posedge refClk or posedge sysRst) begin
      if (sysRst) oeCnt_q <= 9'h000;
      else if (upstreamDataOe) oeCnt_q <= oeCnt_q + 9'h001;
      else oeCnt_q <= 9'h000;
   end

   default clocking cb @(posedge refClk);
   endclocking
   default disable iff (sysRst);

   sequence s_acceptClean;
      cmdAccepted && !cmdPending;
   endsequence
   sequence s_hookMatch;
      hookControl[3] == cmdActive.onHookMonitor && hookControl[0] == cmdActive.offHookRequest;
   endsequence

   a_accept_single: assert property (cmdAccepted |=> !cmdAccepted)
      else $error("accept pulse longer than one cycle");
   a_accept_clears: assert property (cmdAccepted |-> s_acceptClean)
      else $error("pending still set at accept");
   a_accept_pending: assert property ($rose(cmdAccepted) |-> $past(cmdPending))
      else $error("accept without a pending value");
   a_primary_change: assert property (
      $changed(cmdActive) |-> cmdAccepted || $past(cmdAccepted))
      else $error("primary changed without accept");
   a_pending_holds: assert property ($rose(cmdPending) |=> cmdPending[*8])
      else $error("secondary dropped too early");
   a_hook_follows: assert property (cmdAccepted |=> s_hookMatch)
      else $error("hook bits do not follow accepted commands");
   a_idle_levels: assert property (handshakeIdle |-> rxMr && rxMx)
      else $error("idle while a handshake bit is active");
   a_upstream_idle: assert property (!upstreamDataOe |-> upstreamDataPin)
      else $error("upstream line low outside slot");
   a_slot_first_bit: assert property (
      $rose(upstreamDataOe) |-> upstreamDataPin == gsc_pkg::TX_RESERVED_LEVEL)
      else $error("first upstream bit wrong");
   a_slot_length: assert property ($fell(upstreamDataOe) |-> oeCnt_q inside {[248:252]})
      else $error("upstream slot not eight bits long");
endmodule // gsc_sc_channel_asserts

bind gsc_sc_channel gsc_sc_channel_asserts chk (.refClk, .sysRst, .upstreamDataPin,
   .upstreamDataOe, .hookControl, .cmdActive, .cmdAccepted, .cmdPending, .rxMr, .rxMx,
   .handshakeIdle);

/* tb/gsc_host_model.sv */
module gsc_host_model (
   output logic      linkClk,
   output logic      frameSync,
   output logic      downstreamDataPin,
   input  wire logic upstreamDataPin,
   input  wire logic upstreamDataOe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic started;

   initial begin
      linkClk = 1'b0;
      frameSync = 1'b0;
      downstreamDataPin = 1'b1;
      started = 1'b0;
   end

   // one 256-bit frame; link clock stands still between calls
   task automatic run_frame(input logic [7:0] dn, output logic [7:0] up, output logic oeOk);
      int n;
      oeOk = 1'b1;
      up = 8'h00;
      if (!started) repeat (2) begin
         #62.5 linkClk = 1'b1;
         #62.5 linkClk = 1'b0;
      end
      for (int e = 0; e < 512; e++) begin
         n = e / 2;
         frameSync = (e == 0);
         // slot bits 24..31 msb first, pull-up level elsewhere
         if (!e[0]) begin
            downstreamDataPin = (n >= 24 && n < 32) ? dn[31 - n] : 1'b1;
         end
         #62.5 linkClk = 1'b1;
         if (e[0] && n >= 24 && n < 32) begin
            up[31 - n] = upstreamDataPin;
            oeOk &= upstreamDataOe;
         end
         if (e[0] && (n == 23 || n == 33)) oeOk &= !upstreamDataOe;
         #62.5 linkClk = 1'b0;
      end
      frameSync = 1'b0;
      downstreamDataPin = 1'b1;
      started = 1'b1;
   endtask
endmodule // gsc_host_model

/* tb/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic                  refClk = 1'b0;
   logic                  sysRst = 1'b1;
   logic                  linkClk, frameSync, downstreamDataPin, upstreamDataPin, upstreamDataOe;
   gsc_pkg::gsc_status_s  lineStatus = '0;
   gsc_pkg::gsc_reg_req_s regReq = '0;
   logic [7:0]            regRdData, hookControl;
   gsc_pkg::gsc_cmd_s     cmdActive;
   logic                  cmdAccepted, cmdPending, rxMr, rxMx, handshakeIdle;
   int                    nFail = 0;
   int                    checksDone = 0;
   int                    accCount = 0;

   // per-frame command stimulus and expectations
   logic [5:0] cmdTab [9] = '{6'h00, 6'h09, 6'h09, 6'h06, 6'h14, 6'h14, 6'h06, 6'h14, 6'h06};
   logic [5:0] actTab [9] = '{6'h00, 6'h00, 6'h09, 6'h09, 6'h09, 6'h14, 6'h14, 6'h14, 6'h14};
   logic [7:0] accTab [9] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h02};
   logic [1:0] hsTab [9] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h1, 2'h3, 2'h3};
   logic [8:0] pendTab = 9'h15A;
   logic [8:0] idleTab = 9'h132;
   logic [8:0] hookTab = 9'h01C;

   always #4 refClk = ~refClk;
   always @(posedge refClk) if (cmdAccepted === 1'b1) accCount <= accCount + 1;

   gsc_sc_channel #(.SUBFRAME(0)) uut (.refClk, .sysRst, .linkClk, .frameSync,
      .downstreamDataPin, .upstreamDataPin, .upstreamDataOe, .lineStatus, .regReq, .regRdData,
      .hookControl, .cmdActive, .cmdAccepted, .cmdPending, .rxMr, .rxMx, .handshakeIdle);

   gsc_host_model host (.linkClk, .frameSync, .downstreamDataPin, .upstreamDataPin,
      .upstreamDataOe);

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      checksDone++;
      if (seen !== exp) begin
         nFail++;
         $display("Error at %0t ns: %s got %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic conclude();
      if (nFail == 0 && checksDone > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic reg_op(input logic wr, input logic rd, input logic [7:0] addr,
                         input logic [7:0] data);
      @(posedge refClk);
      regReq <= '{wrEn: wr, rdEn: rd, addr: addr, wrData: data};
      @(posedge refClk);
      regReq <= '0;
      @(posedge refClk);
      #1;
   endtask

   task automatic t_reset_values();
      check({2'h0, cmdActive}, {2'h0, gsc_pkg::CMD_RESET}, "primary after reset");
      check({7'h00, cmdPending}, 8'h00, "pending after reset");
      check({5'h00, rxMr, rxMx, handshakeIdle}, 8'h06, "handshake after reset");
      check({6'h00, upstreamDataPin, upstreamDataOe}, 8'h02, "upstream at rest");
      check(hookControl, gsc_pkg::HOOK_CONTROL_RESET, "hook reset value");
   endtask

   task automatic t_registers();
      reg_op(1'b1, 1'b0, gsc_pkg::REG_LINE_HOOK_CONTROL, 8'hF6);
      check(hookControl, 8'hF6, "hook write");
      reg_op(1'b0, 1'b1, gsc_pkg::REG_LINE_HOOK_CONTROL, 8'h00);
      check(regRdData, 8'hF6, "hook read");
      reg_op(1'b0, 1'b1, 8'h85, 8'h00);
      check(regRdData, gsc_pkg::READ_UNMAPPED, "upper address bit");
      reg_op(1'b1, 1'b0, gsc_pkg::REG_LINE_FAULT_STATUS, 8'hFF);
      check(hookControl, 8'hF6, "read-only write ignored");
      @(posedge refClk);
      lineStatus.dropOutDetect <= 1'b1;
      reg_op(1'b0, 1'b1, gsc_pkg::REG_LINE_FAULT_STATUS, 8'h00);
      check(regRdData, 8'h01 << gsc_pkg::FAULT_DROP_OUT_BIT, "fault status read");
   endtask

   task automatic t_frames();
      logic [7:0] up;
      logic [7:0] expUp;
      logic       oeOk;
      for (int i = 0; i < 9; i++) begin
         @(posedge refClk);
         lineStatus <= '{thresholdCrossIndication: i[0], dropOutDetect: i[1], intPinLevel: i[2],
                         tipGroundDetect: i[3], lineVoltageStatus: {~i[0], 7'h2A}};
         host.run_frame({cmdTab[i], hsTab[i]}, up, oeOk);
         expUp = {gsc_pkg::TX_RESERVED_LEVEL, i[0], i[1], i[2], ~i[0], i[3], 2'h3};
         check(up, expUp, "upstream sc byte");
         check({7'h00, oeOk}, 8'h01, "upstream slot enable");
         check({2'h0, cmdActive}, {2'h0, actTab[i]}, "primary command");
         check({7'h00, cmdPending}, {7'h00, pendTab[i]}, "secondary pending");
         check(accCount[7:0], accTab[i], "acceptance count");
         check({6'h00, rxMr, rxMx}, {6'h00, hsTab[i]}, "received mr mx");
         check({7'h00, handshakeIdle}, {7'h00, idleTab[i]}, "handshake idle");
         check(hookControl, hookTab[i] ? 8'hFF : 8'hF6, "hook follows commands");
      end
   endtask

   initial begin
      repeat (12) @(posedge refClk);
      sysRst <= 1'b0;
      @(posedge refClk);
      #1;
      t_reset_values();
      t_registers();
      t_frames();
      conclude();
   end
endmodule // testbench
